// ---- hw/process_data_telegram_codec.sv ----
// top of the drive-side process-data telegram codec
// assumes a byte stream from the fieldbus interface on the same clock;
// rx_start_in marks the first byte of each 16-byte receive telegram
`timescale 1ns/10ps
`include "telegram_consts.svh"
module process_data_telegram_codec
(
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   // receive byte stream
   input  wire logic        rx_valid_in,
   input  wire logic        rx_start_in,
   input  wire logic [7:0]  rx_data_in,
   // response request and stream
   input  wire logic        tx_req_in,
   input  wire logic        tx_ready_in,
   output logic             tx_valid_out,
   output logic             tx_last_out,
   output logic      [7:0]  tx_data_out,
   // drive actual values
   input  wire logic [7:0]  act_mode_in,
   input  wire logic [15:0] act_status_in,
   input  wire logic [31:0] act_position_in,
   input  wire logic [31:0] act_speed_in,
   input  wire logic [31:0] act_current_in,
   input  wire logic [31:0] act_inputs_in,
   // decoded setpoints
   output logic             cmd_update_out,
   output logic             speed_mode_out,
   output logic             position_mode_out,
   output logic      [15:0] control_word_out,
   output logic      [31:0] speed_setpoint_out,
   output logic      [31:0] target_position_out,
   output logic      [31:0] travel_speed_out,
   output logic      [31:0] accel_out,
   output logic             rx_reject_out
);

   // ****************************************************************
   // receive side
   // ****************************************************************
   telegram_pkg::rx_state_t  rx_state;
   telegram_pkg::ctrl_mode_t rx_mode;
   logic [3:0]  rx_idx;
   logic        rx_done;
   logic [4:0]  ld_idx;
   logic        ld_busy;
   logic [7:0]  buf_rd;
   logic        ld_valid;
   logic [4:0]  ld_idx_q;
   logic [127:0] frame;
   telegram_pkg::ctrl_mode_t ld_mode;

   // identifier chooses layout; anything else drops the frame
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         rx_state <= telegram_pkg::rx_idle;
         rx_mode  <= telegram_pkg::mode_none;
         rx_idx   <= 4'h0;
         rx_done  <= 1'b0;
      end
      else
      begin
         rx_done <= 1'b0;
         if (rx_valid_in && rx_start_in)
         begin
            rx_idx <= 4'h1;
            case (rx_data_in)
               `ID_SPEED_RX:
               begin
                  rx_mode  <= telegram_pkg::mode_speed;
                  rx_state <= telegram_pkg::rx_body;
               end
               `ID_POSITION_RX:
               begin
                  rx_mode  <= telegram_pkg::mode_position;
                  rx_state <= telegram_pkg::rx_body;
               end
               default:
                  rx_state <= telegram_pkg::rx_drop;
            endcase
         end
         else if (rx_valid_in)
         begin
            case (rx_state)
               telegram_pkg::rx_body:
               begin
                  rx_idx <= rx_idx + 4'h1;
                  if (rx_idx == 4'(`RX_LEN - 5'h1))
                  begin
                     rx_done  <= 1'b1;
                     rx_state <= telegram_pkg::rx_idle;
                  end
               end
               telegram_pkg::rx_drop:
                  rx_state <= telegram_pkg::rx_drop;
               default:
                  rx_state <= telegram_pkg::rx_idle;
            endcase
         end
      end
   end

   rx_frame_buffer #(.DEPTH(16)) u_buf
   (
      .mclk_in     (mclk_in),
      .wr_en_in    (rx_valid_in && !rx_start_in && rx_state == telegram_pkg::rx_body),
      .wr_addr_in  (rx_idx),
      .wr_data_in  (rx_data_in),
      .rd_addr_in  (ld_idx[3:0]),
      .rd_data_out (buf_rd)
   );

   // after a full frame, unload bytes 2..15 into a shadow word;
   // the layout is latched too, as a following start byte may change rx_mode meanwhile
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ld_busy  <= 1'b0;
         ld_idx   <= 5'h00;
         ld_valid <= 1'b0;
         ld_idx_q <= 5'h00;
         ld_mode  <= telegram_pkg::mode_none;
      end
      else
      begin
         ld_valid <= ld_busy;
         ld_idx_q <= ld_idx;
         if (rx_done)
         begin
            ld_busy <= 1'b1;
            ld_idx  <= `OFS_WORD;
            ld_mode <= rx_mode;
         end
         else if (ld_busy)
         begin
            ld_idx <= ld_idx + 5'h01;
            if (ld_idx == `RX_LEN - 5'h01)
               ld_busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
         frame <= 128'h0;
      else if (ld_valid)
         frame[8'(127 - 8 * ld_idx_q) -: 8] <= buf_rd;
   end

   logic apply;
   logic ld_busy_q;

   // fields become effective once the last byte has been unloaded
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ld_busy_q <= 1'b0;
         apply     <= 1'b0;
      end
      else
      begin
         ld_busy_q <= ld_valid;
         apply     <= ld_busy_q && !ld_valid;
      end
   end

   // field extraction; the filler of the speed layout is never read
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         cmd_update_out      <= 1'b0;
         speed_mode_out      <= 1'b0;
         position_mode_out   <= 1'b0;
         control_word_out    <= `RST_WORD;
         speed_setpoint_out  <= `RST_VALUE;
         target_position_out <= `RST_VALUE;
         travel_speed_out    <= `RST_VALUE;
         accel_out           <= `RST_VALUE;
      end
      else
      begin
         cmd_update_out <= apply;
         if (apply)
         begin
            control_word_out <= frame[111:96];
            if (ld_mode == telegram_pkg::mode_speed)
            begin
               speed_mode_out     <= 1'b1;
               position_mode_out  <= 1'b0;
               speed_setpoint_out <= frame[95:64];
               accel_out          <= frame[63:32];
            end
            else
            begin
               speed_mode_out      <= 1'b0;
               position_mode_out   <= 1'b1;
               target_position_out <= frame[95:64];
               travel_speed_out    <= frame[63:32];
               accel_out           <= frame[31:0];
            end
         end
      end
   end

   // reject pulse for a frame with an unknown identifier
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
         rx_reject_out <= 1'b0;
      else
         rx_reject_out <= rx_valid_in && rx_start_in &&
                          rx_data_in != `ID_SPEED_RX && rx_data_in != `ID_POSITION_RX;
   end

   // ****************************************************************
   // response side
   // ****************************************************************
   logic [4:0]  tx_idx;
   logic        tx_busy;
   logic [7:0]  mux_byte;
   logic        fetch;
   logic        fetch_wait;
   logic [7:0]  snap_mode;
   logic [15:0] snap_status;
   logic [31:0] snap_pos;
   logic [31:0] snap_speed;
   logic [31:0] snap_cur;
   logic [31:0] snap_dig;

   // snapshot of actual values keeps one response consistent
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         snap_mode   <= 8'h00;
         snap_status <= `RST_WORD;
         snap_pos    <= `RST_VALUE;
         snap_speed  <= `RST_VALUE;
         snap_cur    <= `RST_VALUE;
         snap_dig    <= `RST_VALUE;
      end
      else if (tx_req_in && !tx_busy)
      begin
         snap_mode   <= act_mode_in;
         snap_status <= act_status_in;
         snap_pos    <= act_position_in;
         snap_speed  <= act_speed_in;
         snap_cur    <= act_current_in;
         snap_dig    <= act_inputs_in;
      end
   end

   tx_byte_mux u_mux
   (
      .mclk_in    (mclk_in),
      .reset_in   (reset_in),
      .idx_in     (tx_idx),
      .mode_in    (snap_mode),
      .status_in  (snap_status),
      .pos_in     (snap_pos),
      .speed_in   (snap_speed),
      .current_in (snap_cur),
      .dig_in     (snap_dig),
      .byte_out   (mux_byte)
   );

   // byte sequencer: two fetch cycles, then present byte until taken;
   // the byte mux is registered, so its output trails the index by one cycle
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         tx_busy      <= 1'b0;
         fetch        <= 1'b0;
         fetch_wait   <= 1'b0;
         tx_idx       <= 5'h00;
         tx_valid_out <= 1'b0;
         tx_last_out  <= 1'b0;
         tx_data_out  <= 8'h00;
      end
      else if (!tx_busy)
      begin
         if (tx_req_in)
         begin
            tx_busy <= 1'b1;
            tx_idx  <= `OFS_ID;
            fetch   <= 1'b1;
         end
      end
      else if (fetch)
      begin
         fetch      <= 1'b0;
         fetch_wait <= 1'b1;
      end
      else if (fetch_wait)
      begin
         fetch_wait   <= 1'b0;
         tx_valid_out <= 1'b1;
         tx_data_out  <= mux_byte;
         tx_last_out  <= (tx_idx == `TX_LEN - 5'h01);
      end
      else if (tx_valid_out && tx_ready_in)
      begin
         tx_valid_out <= 1'b0;
         tx_last_out  <= 1'b0;
         if (tx_last_out)
            tx_busy <= 1'b0;
         else
         begin
            tx_idx <= tx_idx + 5'h01;
            fetch  <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_reject_keeps: assert property (@(posedge mclk_in) disable iff (reset_in)
      rx_reject_out |-> ##1 $stable(control_word_out))
      else $error("rejected frame changed setpoints");

   chk_first_byte_id: assert property (@(posedge mclk_in) disable iff (reset_in)
      (tx_valid_out && tx_idx == `OFS_ID) |-> tx_data_out == `ID_RESPONSE)
      else $error("response byte 0 not identifier");

   chk_mode_byte: assert property (@(posedge mclk_in) disable iff (reset_in)
      (tx_valid_out && tx_idx == `OFS_MODE) |-> tx_data_out == snap_mode)
      else $error("response byte 1 not mode");

   chk_status_msb: assert property (@(posedge mclk_in) disable iff (reset_in)
      (tx_valid_out && tx_idx == `OFS_WORD) |-> tx_data_out == snap_status[15:8])
      else $error("status msb misplaced");

   chk_pos_msb: assert property (@(posedge mclk_in) disable iff (reset_in)
      (tx_valid_out && tx_idx == `OFS_VAL_A) |-> tx_data_out == snap_pos[31:24])
      else $error("position msb misplaced");

   chk_speed_msb: assert property (@(posedge mclk_in) disable iff (reset_in)
      (tx_valid_out && tx_idx == `OFS_VAL_B) |-> tx_data_out == snap_speed[31:24])
      else $error("speed msb misplaced");

   chk_cur_lsb: assert property (@(posedge mclk_in) disable iff (reset_in)
      (tx_valid_out && tx_idx == 5'h0f) |-> tx_data_out == snap_cur[7:0])
      else $error("current lsb misplaced");

   chk_dig_msb: assert property (@(posedge mclk_in) disable iff (reset_in)
      (tx_valid_out && tx_idx == `OFS_VAL_D) |-> tx_data_out == snap_dig[31:24])
      else $error("inputs msb misplaced");

   chk_last_index: assert property (@(posedge mclk_in) disable iff (reset_in)
      tx_last_out |-> tx_idx == 5'h13)
      else $error("last not on byte 19");

   chk_update_mode: assert property (@(posedge mclk_in) disable iff (reset_in)
      cmd_update_out |-> (speed_mode_out != position_mode_out))
      else $error("mode flags inconsistent");

   chk_done_after16: assert property (@(posedge mclk_in) disable iff (reset_in)
      rx_done |-> $past(rx_idx) == 4'hf)
      else $error("frame end not at byte 15");

   chk_apply_delay: assert property (@(posedge mclk_in) disable iff (reset_in)
      rx_done |-> ##18 cmd_update_out)
      else $error("setpoints not applied in time");

endmodule

// ---- hw/telegram_consts.svh ----
// constants of the cyclic process-data telegram codec: offsets, identifiers, lengths
// assumes inclusion by bare name from design files; definitions only
`ifndef TELEGRAM_CONSTS_SVH
`define TELEGRAM_CONSTS_SVH

// ****************************************************************
// identifiers and lengths
// ****************************************************************
`define ID_SPEED_RX      8'he1
`define ID_POSITION_RX   8'he0
`define ID_RESPONSE      8'hf0
`define RX_LEN           5'h10
`define TX_LEN           5'h14

// ****************************************************************
// field offsets
// ****************************************************************
`define OFS_ID           5'h00
`define OFS_MODE         5'h01
`define OFS_WORD         5'h02
`define OFS_VAL_A        5'h04
`define OFS_VAL_B        5'h08
`define OFS_VAL_C        5'h0c
`define OFS_VAL_D        5'h10

// ****************************************************************
// reset values
// ****************************************************************
`define RST_WORD         16'h0000
`define RST_VALUE        32'h0000_0000

`endif

// ---- hw/telegram_pkg.sv ----
// types of the process-data telegram codec
// assumes nothing of its surroundings
package telegram_pkg;
   typedef enum logic [1:0] {mode_none, mode_speed, mode_position} ctrl_mode_t;
   typedef enum {rx_idle, rx_body, rx_drop} rx_state_t;
endpackage

// ---- hw/rx_frame_buffer.sv ----
// sixteen-byte receive staging memory with registered read
// assumes writes and reads on one clock; no reset needed on data
`timescale 1ns/10ps
module rx_frame_buffer
#(
   parameter int DEPTH = 16
)
(
   input  wire logic       mclk_in,
   input  wire logic       wr_en_in,
   input  wire logic [3:0] wr_addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic [3:0] rd_addr_in,
   output logic      [7:0] rd_data_out
);
   logic [7:0] mem [DEPTH];

   // the address ports are four bits wide, so no other depth can be served
   if (DEPTH != 16)
   begin
      $error("rx_frame_buffer depth must be 16");
   end

   // plain write port
   always_ff @(posedge mclk_in)
   begin
      if (wr_en_in)
      begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // read data leaves through a register
   always_ff @(posedge mclk_in)
   begin
      rd_data_out <= mem[rd_addr_in];
   end
endmodule

// ---- hw/tx_byte_mux.sv ----
// picks one byte of the 20-byte response telegram by index
// assumes all inputs are stable for the frame; output registered
`timescale 1ns/10ps
`include "telegram_consts.svh"
module tx_byte_mux
(
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic [4:0]  idx_in,
   input  wire logic [7:0]  mode_in,
   input  wire logic [15:0] status_in,
   input  wire logic [31:0] pos_in,
   input  wire logic [31:0] speed_in,
   input  wire logic [31:0] current_in,
   input  wire logic [31:0] dig_in,
   output logic      [7:0]  byte_out
);
   // byte k of a big-endian 32-bit field
   function automatic logic [7:0] be_byte(input logic [31:0] v, input logic [1:0] k);
      be_byte = v[8'(31 - 8 * k) -: 8];
   endfunction

   logic [7:0] next_byte;

   // fixed layout, most significant byte first
   always_comb
   begin
      next_byte = 8'h00;
      if (idx_in == `OFS_ID)
         next_byte = `ID_RESPONSE;
      else if (idx_in == `OFS_MODE)
         next_byte = mode_in;
      else if (idx_in < `OFS_VAL_A)
         next_byte = idx_in[0] ? status_in[7:0] : status_in[15:8];
      else if (idx_in < `OFS_VAL_B)
         next_byte = be_byte(pos_in, idx_in[1:0]);
      else if (idx_in < `OFS_VAL_C)
         next_byte = be_byte(speed_in, idx_in[1:0]);
      else if (idx_in < `OFS_VAL_D)
         next_byte = be_byte(current_in, idx_in[1:0]);
      else if (idx_in < `TX_LEN)
         next_byte = be_byte(dig_in, idx_in[1:0]);
   end

   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
         byte_out <= 8'h00;
      else
         byte_out <= next_byte;
   end
endmodule

// ---- bench/fieldbus_master_model.sv ----
// behavioural fieldbus master: sends receive telegrams, collects response telegrams
// assumes the codec byte-stream contract; every signal changes on the falling edge
`timescale 1ns/10ps
module fieldbus_master_model
(
   input  wire logic       mclk_in,
   output logic            rx_valid_out,
   output logic            rx_start_out,
   output logic      [7:0] rx_data_out,
   output logic            tx_req_out,
   output logic            tx_ready_out,
   input  wire logic       tx_valid_in,
   input  wire logic       tx_last_in,
   input  wire logic [7:0] tx_data_in
);
   // ****************************************************************
   // idle levels
   // ****************************************************************
   initial
   begin
      rx_valid_out = 1'b0;
      rx_start_out = 1'b0;
      rx_data_out  = 8'h00;
      tx_req_out   = 1'b0;
      tx_ready_out = 1'b0;
   end

   // ****************************************************************
   // receive telegram, first byte first; n below 16 cuts it short
   // ****************************************************************
   task automatic send_frame(input logic [127:0] frame, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge mclk_in);
         rx_valid_out <= 1'b1;
         rx_start_out <= (i == 0);
         rx_data_out  <= frame[127 - 8 * i -: 8];
      end
      @(negedge mclk_in);
      rx_valid_out <= 1'b0;
      rx_start_out <= 1'b0;
      rx_data_out  <= ~rx_data_out; // a released line must not look like the last byte
   endtask

   // bounded wait for the response valid flag to reach a level
   task automatic wait_valid(input logic lvl, inout bit hung);
      int w;
      w = 0;
      while (tx_valid_in !== lvl && w < 12)
      begin
         @(negedge mclk_in);
         w++;
      end
      hung |= (w == 12);
   endtask

   // ****************************************************************
   // response telegram; stall holds ready low before each byte
   // ****************************************************************
   task automatic read_response(input int stall, output logic [159:0] resp, output logic [19:0] lasts,
                                output bit hung);
      hung = 1'b0;
      @(negedge mclk_in);
      tx_req_out <= 1'b1;
      @(negedge mclk_in);
      tx_req_out <= 1'b0;
      for (int i = 0; i < 20; i++)
      begin
         wait_valid(1'b1, hung);
         repeat (stall) @(negedge mclk_in);
         tx_ready_out <= 1'b1;
         @(posedge mclk_in);
         resp[159 - 8 * i -: 8] = tx_data_in;
         lasts[19 - i]          = tx_last_in;
         @(negedge mclk_in);
         tx_ready_out <= 1'b0;
         // the byte just taken must drop before the next one counts
         wait_valid(1'b0, hung);
      end
   endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench of the process-data telegram codec
// assumes the fieldbus master model drives the byte streams; bench drives actual values
`timescale 1ns/10ps
module testbench;
   localparam logic [127:0] SPD  = {8'he1, 8'h5a, 16'h1234, 32'h8765_4321, 32'h0000_0fa0, 32'hdead_beef};
   localparam logic [127:0] POS  = {8'he0, 8'ha5, 16'h0f3f, 32'hfff0_0001, 32'h0000_2710, 32'h0001_86a0};
   localparam logic [127:0] SPD2 = {8'he1, 8'h00, 16'h8001, 32'h0000_0064, 32'h0000_01f4, 32'h1111_2222};
   localparam logic [127:0] BAD  = {8'he2, 8'h00, 16'hffff, 32'h5555_5555, 32'h6666_6666, 32'h7777_7777};

   logic        mclk_in, reset_in, rx_valid_in, rx_start_in, tx_req_in, tx_ready_in;
   logic [7:0]  rx_data_in, tx_data_out, act_mode_in;
   logic        tx_valid_out, tx_last_out, cmd_update_out, speed_mode_out, position_mode_out, rx_reject_out;
   logic [15:0] act_status_in, control_word_out;
   logic [31:0] act_position_in, act_speed_in, act_current_in, act_inputs_in;
   logic [31:0] speed_setpoint_out, target_position_out, travel_speed_out, accel_out;
   int          failures, n_checks, n_update, n_reject, cycles;

   process_data_telegram_codec process_data_telegram_codec_i (.mclk_in(mclk_in), .reset_in(reset_in),
      .rx_valid_in(rx_valid_in), .rx_start_in(rx_start_in), .rx_data_in(rx_data_in), .tx_req_in(tx_req_in),
      .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out),
      .tx_data_out(tx_data_out), .act_mode_in(act_mode_in), .act_status_in(act_status_in),
      .act_position_in(act_position_in), .act_speed_in(act_speed_in), .act_current_in(act_current_in),
      .act_inputs_in(act_inputs_in), .cmd_update_out(cmd_update_out), .speed_mode_out(speed_mode_out),
      .position_mode_out(position_mode_out), .control_word_out(control_word_out),
      .speed_setpoint_out(speed_setpoint_out), .target_position_out(target_position_out),
      .travel_speed_out(travel_speed_out), .accel_out(accel_out), .rx_reject_out(rx_reject_out));

   fieldbus_master_model model_i (.mclk_in(mclk_in), .rx_valid_out(rx_valid_in), .rx_start_out(rx_start_in),
      .rx_data_out(rx_data_in), .tx_req_out(tx_req_in), .tx_ready_out(tx_ready_in),
      .tx_valid_in(tx_valid_out), .tx_last_in(tx_last_out), .tx_data_in(tx_data_out));

   // ****************************************************************
   // clock, pulse counters and hang guard
   // ****************************************************************
   initial
   begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   // pulses are counted so a scenario can judge them after the frame ends
   always @(posedge mclk_in)
   begin
      if (cmd_update_out === 1'b1) n_update++;
      if (rx_reject_out === 1'b1) n_reject++;
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check_value(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic send_and_wait(input logic [127:0] f);
      model_i.send_frame(f, 16);
      repeat (40) @(negedge mclk_in);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic test_reset();
      check_value("speed mode", 32'h0, speed_mode_out);
      check_value("tx valid", 32'h0, tx_valid_out);
      check_value("control word", 32'h0, control_word_out);
      $display("test reset done");
   endtask

   // a speed frame must leave target and travel untouched
   task automatic test_speed(input logic [127:0] f, input int cut);
      int u;
      logic [31:0] tgt;
      logic [31:0] trv;
      u = n_update;
      tgt = target_position_out;
      trv = travel_speed_out;
      if (cut > 0) model_i.send_frame(POS, cut); // a fresh start aborts this short frame
      send_and_wait(f);
      check_value("update count", 32'(u + 1), 32'(n_update));
      check_value("speed mode", 32'h1, speed_mode_out);
      check_value("position mode", 32'h0, position_mode_out);
      check_value("control word", f[111:96], control_word_out);
      check_value("speed setpoint", f[95:64], speed_setpoint_out);
      check_value("accel", f[63:32], accel_out);
      check_value("target", tgt, target_position_out);
      check_value("travel", trv, travel_speed_out);
      $display("test speed frame done");
   endtask

   task automatic test_position();
      logic [31:0] spd;
      spd = speed_setpoint_out;
      send_and_wait(POS);
      check_value("position mode", 32'h1, position_mode_out);
      check_value("speed mode", 32'h0, speed_mode_out);
      check_value("control word", POS[111:96], control_word_out);
      check_value("target", POS[95:64], target_position_out);
      check_value("travel", POS[63:32], travel_speed_out);
      check_value("accel", POS[31:0], accel_out);
      check_value("speed setpoint kept", spd, speed_setpoint_out);
      $display("test position frame done");
   endtask

   task automatic test_bad_id();
      int u;
      int r;
      logic [31:0] cw;
      logic [31:0] tgt;
      u = n_update;
      r = n_reject;
      cw = control_word_out;
      tgt = target_position_out;
      send_and_wait(BAD);
      check_value("reject count", 32'(r + 1), 32'(n_reject));
      check_value("update count", 32'(u), 32'(n_update));
      check_value("control word kept", cw, control_word_out);
      check_value("target kept", tgt, target_position_out);
      check_value("position mode kept", 32'h1, position_mode_out);
      $display("test bad identifier done");
   endtask

   task automatic test_response(input int stall, input logic [31:0] base);
      logic [159:0] exp;
      logic [159:0] resp;
      logic [19:0]  lasts;
      bit           hung;
      @(negedge mclk_in);
      act_mode_in     = base[7:0];
      act_status_in   = base[31:16] ^ 16'h00ff;
      act_position_in = base;
      act_speed_in    = ~base;
      act_current_in  = {base[15:0], base[31:16]};
      act_inputs_in   = base ^ 32'h0f0f_0f0f;
      exp = {8'hf0, act_mode_in, act_status_in, act_position_in, act_speed_in, act_current_in, act_inputs_in};
      model_i.read_response(stall, resp, lasts, hung);
      for (int i = 0; i < 20; i++)
         check_value("response byte", 32'(exp[159 - 8 * i -: 8]), 32'(resp[159 - 8 * i -: 8]));
      check_value("last flags", 32'h0000_0001, 32'(lasts));
      check_value("response stalled", 32'h0, 32'(hung));
      $display("test response stall %0d done", stall);
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      failures = 0;
      n_checks = 0;
      n_update = 0;
      n_reject = 0;
      cycles = 0;
      reset_in = 1'b1;
      act_mode_in = 8'h00;
      act_status_in = 16'h0000;
      act_position_in = 32'h0;
      act_speed_in = 32'h0;
      act_current_in = 32'h0;
      act_inputs_in = 32'h0;
      repeat (6) @(posedge mclk_in);
      @(negedge mclk_in);
      reset_in = 1'b0;
      @(negedge mclk_in);
      test_reset();
      test_speed(SPD, 0);
      test_position();
      test_bad_id();
      test_response(0, 32'h8123_45c6);
      test_response(3, 32'h0000_7ffe);
      test_speed(SPD2, 8);
      print_verdict();
   end
endmodule
